//--- sonet_tx_overhead_scrambler.sv
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - STS-3 mode takes every fourth byte and repeats each bit four times.
// - All twelve A1 bytes become F6 and all twelve A2 bytes 28.
// - First A1 bit leaves five to seven byte clocks after frame pulse.
// - Corruption replaces only the last A1 and first A2 byte.
// - Error insert enable sends corrupted values for the programmed frame count.
// - Frame count zero corrupts until software clears the enable.
// - After a finite burst, corruption restarts only after enable clears and sets.
// - Framing insert disable leaves A1/A2 positions as received.
// - BIP-8 over previous scrambled frame goes into B1 before scrambling.
// - Only first STS-1 carries parity; other eleven B1 positions are zero.
// - Each set force-invert bit flips the matching BIP-8 bit.
// - Per-stream fault enable gates the parity inversion.
// - Parity insert disable leaves B1 positions as received.
// - Frame-synchronous scrambler, length 127, polynomial 1 + x^6 + x^7.
// - Scrambler loads all ones on first payload byte, then runs on.
// - A1, A2, J0 and Z0 bytes bypass the scrambler.
// - A control bit disables scrambling.
// - Scrambled data goes to both work and protect outputs.
// - Byte path runs at 77.76 MHz for a 622 Mbit/s stream.
module sonet_tx_overhead_scrambler (
	input  wire logic        CLK_SYS,      // 250 MHz system clock
	input  wire logic        ARST_N,       // Async reset, low
	input  wire logic [7:0]  TX_DATA,      // Byte from overhead insert stage
	input  wire logic        TX_FP,        // Frame pulse with first A1 byte
	input  wire logic        REG_WR,       // Register write strobe
	input  wire logic [17:0] REG_ADDR,     // Register address
	input  wire logic [7:0]  REG_WDATA,    // Register write data
	output logic      [7:0]  REG_RDATA,    // Register read data
	output logic             BYTE_EN,      // Byte clock enable pulse
	output logic      [7:0]  TX_WORK_DATA, // Byte to work serializer
	output logic      [7:0]  TX_PROT_DATA, // Byte to protect serializer
	output logic             TX_OUT_VALID, // Output byte strobe
	output logic             TX_OUT_FP     // First A1 byte on output
);
	import sonet_tx_pkg::*;

	// Fractional divider: 250 MHz down to 77.76 MHz enable
	logic [17:0] acc;
	wire  [18:0] acc_sum = {1'b0, acc} + 19'(BYTE_CLK_KHZ);
	wire         acc_wrap = acc_sum >= 19'(SYS_CLK_KHZ);

	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			acc     <= 18'h00000;
			BYTE_EN <= 1'b0;
		end else begin
			acc     <= acc_wrap ? 18'(acc_sum - 19'(SYS_CLK_KHZ)) : acc_sum[17:0];
			BYTE_EN <= acc_wrap;
		end
	end

	// Registers
	logic [7:0] frame_count_and_scramble_ctrl;
	logic [7:0] framing_error_insert_ctrl_a;
	logic [7:0] framing_error_insert_ctrl_b;
	logic [7:0] parity_force_invert;
	logic [7:0] corrupt_a2_value;
	logic       burst_done;

	wire sel_fc  = REG_ADDR == OFS_FRAME_COUNT_AND_SCRAMBLE;
	wire sel_ca  = REG_ADDR == OFS_FRAMING_ERR_CTRL_A;
	wire sel_cb  = REG_ADDR == OFS_FRAMING_ERR_CTRL_B;
	wire sel_pf  = REG_ADDR == OFS_PARITY_FORCE_INVERT;
	wire sel_a2v = REG_ADDR == OFS_CORRUPT_A2_VALUE;

	wire [7:0] ctrl_a_rd = {burst_done, framing_error_insert_ctrl_a[6:0]};
	assign REG_RDATA = sel_fc ? frame_count_and_scramble_ctrl :
	                   sel_ca ? ctrl_a_rd :
	                   sel_cb ? framing_error_insert_ctrl_b :
	                   sel_pf ? parity_force_invert :
	                   sel_a2v ? corrupt_a2_value : 8'h00;

	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			frame_count_and_scramble_ctrl <= RST_FRAME_COUNT_AND_SCRAMBLE;
			framing_error_insert_ctrl_a   <= RST_FRAMING_ERR_CTRL_A;
			framing_error_insert_ctrl_b   <= RST_CORRUPT_A1_VALUE;
			parity_force_invert           <= RST_PARITY_FORCE_INVERT;
			corrupt_a2_value              <= RST_CORRUPT_A2_VALUE;
		end else if (REG_WR) begin
			if (sel_fc)
				frame_count_and_scramble_ctrl <= REG_WDATA;
			if (sel_ca)
				framing_error_insert_ctrl_a <= {1'b0, REG_WDATA[6:0]};
			if (sel_cb)
				framing_error_insert_ctrl_b <= REG_WDATA;
			if (sel_pf)
				parity_force_invert <= REG_WDATA;
			if (sel_a2v)
				corrupt_a2_value <= REG_WDATA;
		end
	end

	wire [FRAME_COUNT_W-1:0] frames_to_corrupt = frame_count_and_scramble_ctrl[FRAME_COUNT_W-1:0];
	wire scramble_dis = frame_count_and_scramble_ctrl[BIT_SCRAMBLE_DIS];
	wire err_ins_en   = framing_error_insert_ctrl_a[BIT_ERR_INS_EN];
	wire a1a2_ins_dis = framing_error_insert_ctrl_a[BIT_A1A2_INS_DIS];
	wire b1_ins_dis   = framing_error_insert_ctrl_a[BIT_B1_INS_DIS];
	wire b1_fault_en  = framing_error_insert_ctrl_a[BIT_B1_FAULT_EN];
	wire sts3_mode    = framing_error_insert_ctrl_a[BIT_STS3_MODE];

	// Stage 1: capture byte and its frame position
	logic [7:0]  d1;
	logic [10:0] col;
	logic [3:0]  row;
	logic        fp1;

	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			d1  <= 8'h00;
			fp1 <= 1'b0;
			col <= 11'd0;
			row <= 4'd0;
		end else if (BYTE_EN) begin
			d1  <= TX_DATA;
			fp1 <= TX_FP;
			if (TX_FP) begin
				col <= 11'd0;
				row <= 4'd0;
			end else if (col == 11'(ROW_BYTES - 1)) begin
				col <= 11'd0;
				row <= (row == 4'(FRAME_ROWS - 1)) ? 4'd0 : row + 4'd1;
			end else begin
				col <= col + 11'd1;
			end
		end
	end

	wire row0       = row == 4'd0;
	wire frame_head = fp1;
	wire is_a1      = row0 && col < 11'(STS_PER_FRAME);
	wire is_a2      = row0 && col >= COL_FIRST_A2 && col < COL_J0;
	wire no_scr     = row0 && col < COL_FIRST_PAYLOAD;
	wire first_pay  = row0 && col == COL_FIRST_PAYLOAD;
	wire is_b1      = row == 4'd1 && col == 11'd0;
	wire is_b1_fill = row == 4'd1 && col != 11'd0 && col < 11'(STS_PER_FRAME);

	// Corruption burst tracking, decided once per frame
	logic                     corrupt_active;
	logic [FRAME_COUNT_W-1:0] frames_done;
	wire  [FRAME_COUNT_W-1:0] frames_next = frames_done + 1'b1;

	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			corrupt_active <= 1'b0;
			burst_done     <= 1'b0;
			frames_done    <= '0;
		end else if (!err_ins_en) begin
			corrupt_active <= 1'b0;
			burst_done     <= 1'b0;
			frames_done    <= '0;
		end else if (BYTE_EN && frame_head) begin
			corrupt_active <= !burst_done;
			if (!burst_done) begin
				frames_done <= frames_next;
				// Zero count never finishes the burst
				if (frames_to_corrupt != '0 && frames_next == frames_to_corrupt)
					burst_done <= 1'b1;
			end
		end
	end

	// Overhead substitution ahead of the scrambler
	logic [7:0] bip_prev;
	wire  [7:0] bip_mask = b1_fault_en ? parity_force_invert : 8'h00;
	wire  [7:0] a1_val = (corrupt_active && col == COL_LAST_A1) ? framing_error_insert_ctrl_b : A1_BYTE;
	wire  [7:0] a2_val = (corrupt_active && col == COL_FIRST_A2) ? corrupt_a2_value : A2_BYTE;
	wire  [7:0] pre_scr = (is_a1 && !a1a2_ins_dis) ? a1_val :
	                      (is_a2 && !a1a2_ins_dis) ? a2_val :
	                      (is_b1 && !b1_ins_dis) ? bip_prev ^ bip_mask :
	                      (is_b1_fill && !b1_ins_dis) ? 8'h00 : d1;

	// Byte-wide scrambler: keystream is the MSB-first run of x^7 + x^6 + 1
	function automatic logic [14:0] scr_step(input logic [6:0] s);
		logic [6:0] st;
		logic [7:0] ks;
		st = s;
		ks = 8'h00;
		for (int i = 7; i >= 0; i--) begin
			ks[i] = st[6];
			st    = {st[5:0], st[6] ^ st[5]};
		end
		return {ks, st};
	endfunction

	logic [6:0] scr;
	wire  [6:0] scr_seed = first_pay ? SCR_SEED : scr;
	wire  [14:0] scr_out = scr_step(scr_seed);
	wire  [7:0] post_scr = (scramble_dis || no_scr) ? pre_scr : pre_scr ^ scr_out[14:7];

	// Stage 2: scrambled byte and running parity
	logic [7:0] d2;
	logic       fp2;
	logic [7:0] bip_acc;

	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			scr      <= SCR_SEED;
			d2       <= 8'h00;
			fp2      <= 1'b0;
			bip_acc  <= 8'h00;
			bip_prev <= 8'h00;
		end else if (BYTE_EN) begin
			scr <= scr_out[6:0];
			d2  <= post_scr;
			fp2 <= frame_head;
			if (frame_head) begin
				bip_prev <= bip_acc;
				bip_acc  <= post_scr;
			end else begin
				bip_acc <= bip_acc ^ post_scr;
			end
		end
	end

	// Output delay line sets the frame pulse latency
	logic [7:0] dly_data [OUT_PIPE_DEPTH];
	logic       dly_fp   [OUT_PIPE_DEPTH];

	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			for (int i = 0; i < OUT_PIPE_DEPTH; i++) begin
				dly_data[i] <= 8'h00;
				dly_fp[i]   <= 1'b0;
			end
		end else if (BYTE_EN) begin
			dly_data[0] <= d2;
			dly_fp[0]   <= fp2;
			for (int i = 1; i < OUT_PIPE_DEPTH; i++) begin
				dly_data[i] <= dly_data[i-1];
				dly_fp[i]   <= dly_fp[i-1];
			end
		end
	end

	logic [7:0] rep_data;

	sonet_tx_repeater u_repeater (
		.clk       (CLK_SYS),
		.arst_n    (ARST_N),
		.en        (BYTE_EN),
		.sts3      (sts3_mode),
		.in_data   (dly_data[OUT_PIPE_DEPTH-1]),
		.in_fp     (dly_fp[OUT_PIPE_DEPTH-1]),
		.out_data  (rep_data),
		.out_fp    (TX_OUT_FP),
		.out_valid (TX_OUT_VALID)
	);

	assign TX_WORK_DATA = rep_data;
	assign TX_PROT_DATA = rep_data;

	// Byte clocks since the last input frame pulse, for latency checking
	logic [3:0] since_fp;
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N)
			since_fp <= 4'hF;
		else if (BYTE_EN)
			since_fp <= TX_FP ? 4'd1 : (since_fp == 4'hF ? since_fp : since_fp + 4'd1);
	end

	a_fp_latency: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		$rose(TX_OUT_FP) |-> since_fp >= 4'd5 && since_fp <= 4'd7)
		else $error("frame output latency outside five to seven byte clocks");
	a_a1_pattern: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		BYTE_EN && is_a1 && !a1a2_ins_dis && !(corrupt_active && col == COL_LAST_A1) |=> d2 == A1_BYTE)
		else $error("A1 byte not F6");
	a_a2_corrupt: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		BYTE_EN && corrupt_active && !a1a2_ins_dis && row0 && col == COL_FIRST_A2 |=> d2 == $past(corrupt_a2_value))
		else $error("first A2 not replaced by corrupted value");
	a_burst_stop: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		burst_done && err_ins_en && BYTE_EN && frame_head |=> !corrupt_active)
		else $error("corruption continued after finished burst");
	a_b1_fill: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		BYTE_EN && is_b1_fill && !b1_ins_dis && scramble_dis |=> d2 == 8'h00)
		else $error("B1 fill byte not zero");
	a_b1_invert: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		BYTE_EN && is_b1 && !b1_ins_dis && scramble_dis |=> d2 == ($past(bip_prev) ^ $past(bip_mask)))
		else $error("B1 parity or inversion wrong");
	a_j0_bypass: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		BYTE_EN && row0 && col == COL_J0 |=> d2 == $past(d1))
		else $error("J0 byte was scrambled");
	a_scr_reload: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		BYTE_EN && first_pay && !scramble_dis |=> d2 == ($past(pre_scr) ^ 8'hFE))
		else $error("scrambler not loaded with ones at payload start");
	a_work_prot: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		TX_WORK_DATA == TX_PROT_DATA)
		else $error("work and protect outputs differ");
	a_byte_rate: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
		BYTE_EN |=> !BYTE_EN ##1 !BYTE_EN)
		else $error("byte enable faster than 77.76 MHz");
endmodule
`default_nettype wire

//--- sonet_tx_pkg.sv
package sonet_tx_pkg;
	// Register offsets (byte addresses as printed)
	localparam logic [17:0] OFS_FRAME_COUNT_AND_SCRAMBLE = 18'h3000C;
	localparam logic [17:0] OFS_FRAMING_ERR_CTRL_A       = 18'h3000D;
	localparam logic [17:0] OFS_FRAMING_ERR_CTRL_B       = 18'h3000E;
	localparam logic [17:0] OFS_PARITY_FORCE_INVERT      = 18'h3000F;
	localparam logic [17:0] OFS_CORRUPT_A2_VALUE         = 18'h30010;
	// Field positions
	localparam int BIT_SCRAMBLE_DIS = 6;
	localparam int FRAME_COUNT_W    = 6;
	localparam int BIT_ERR_INS_EN   = 0;
	localparam int BIT_A1A2_INS_DIS = 1;
	localparam int BIT_B1_INS_DIS   = 2;
	localparam int BIT_B1_FAULT_EN  = 3;
	localparam int BIT_STS3_MODE    = 4;
	localparam int BIT_BURST_DONE   = 7;
	// Reset values
	localparam logic [7:0] RST_FRAME_COUNT_AND_SCRAMBLE = 8'h00;
	localparam logic [7:0] RST_FRAMING_ERR_CTRL_A       = 8'h00;
	localparam logic [7:0] RST_CORRUPT_A1_VALUE         = 8'h00;
	localparam logic [7:0] RST_PARITY_FORCE_INVERT      = 8'h00;
	localparam logic [7:0] RST_CORRUPT_A2_VALUE         = 8'h00;
	// Framing pattern
	localparam logic [7:0] A1_BYTE = 8'hF6;
	localparam logic [7:0] A2_BYTE = 8'h28;
	localparam logic [6:0] SCR_SEED = 7'h7F;
	// STS-12 geometry
	localparam int STS_PER_FRAME = 12;
	localparam int ROW_BYTES     = 1080;
	localparam int FRAME_ROWS    = 9;
	localparam logic [10:0] COL_LAST_A1 = 11'd11;
	localparam logic [10:0] COL_FIRST_A2 = 11'd12;
	localparam logic [10:0] COL_J0      = 11'd24;
	localparam logic [10:0] COL_FIRST_PAYLOAD = 11'd36;
	localparam int STS3_COPIES = 4;
	// Byte clock derived from system clock
	localparam int SYS_CLK_KHZ  = 250000;
	localparam int BYTE_CLK_KHZ = 77760;
	localparam int OUT_PIPE_DEPTH = 3;
	localparam int FP_TO_OUT_BYTES = 5;
endpackage

//--- sonet_tx_repeater.sv
`timescale 1ns/100ps
`default_nettype none
module sonet_tx_repeater (
	input  wire logic       clk,      // System clock
	input  wire logic       arst_n,   // Async reset, low
	input  wire logic       en,       // Byte clock enable
	input  wire logic       sts3,     // STS-3 expansion mode
	input  wire logic [7:0] in_data,  // Byte from framer
	input  wire logic       in_fp,    // Frame start marker
	output logic      [7:0] out_data, // Byte to serializer
	output logic            out_fp,   // Frame start, aligned
	output logic            out_valid // One pulse per byte
);
	import sonet_tx_pkg::*;
	logic [1:0] phase;
	logic [7:0] hold;
	// Frame marker forces phase zero so the group lines up with A1
	wire  [1:0] cur_phase = in_fp ? 2'd0 : phase;
	wire  [7:0] src = (cur_phase == 2'd0) ? in_data : hold;
	wire  [2:0] hi_bit = 3'd7 - {cur_phase, 1'b0};
	wire  [2:0] lo_bit = 3'd6 - {cur_phase, 1'b0};
	wire  [7:0] expanded;

	// Two source bits per output byte, earlier bit in the upper nibble
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_exp
			assign expanded[g] = src[(g >= STS3_COPIES) ? hi_bit : lo_bit];
		end
	endgenerate

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			phase     <= 2'd0;
			hold      <= 8'h00;
			out_data  <= 8'h00;
			out_fp    <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			out_valid <= en;
			if (en) begin
				phase  <= cur_phase + 2'd1;
				out_fp <= in_fp;
				if (cur_phase == 2'd0)
					hold <= in_data;
				out_data <= sts3 ? expanded : in_data;
			end
		end
	end

	a_sts3_copies: assert property (@(posedge clk) disable iff (!arst_n)
		en && sts3 && !in_fp && phase == 2'd0 |=> out_data[7:4] == {4{$past(in_data[7])}})
		else $error("sts3 expansion does not repeat bit four times");
	a_sts12_pass: assert property (@(posedge clk) disable iff (!arst_n)
		en && !sts3 |=> out_data == $past(in_data))
		else $error("sts12 byte not passed unchanged");
endmodule
`default_nettype wire

//--- sonet_rx_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module sonet_rx_monitor (
	input  wire logic       clk,    // System clock
	input  wire logic       arst_n, // Async reset, low
	input  wire logic [7:0] data,   // Line byte from work output
	input  wire logic       valid,  // Byte strobe
	input  wire logic       fp      // First A1 byte marker
);
	logic [7:0] cap [0:1091];
	logic [7:0] bip_acc;
	logic [7:0] prev_bip;
	int         pos;
	int         idx;
	// Only the first row and the first twelve bytes of the second are kept; later bytes only feed the parity
	assign idx = fp ? 0 : pos + 1;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pos <= 0;
			bip_acc <= 8'h00;
			prev_bip <= 8'h00;
		end else if (valid) begin
			pos <= idx;
			if (idx < 1092) begin
				cap[idx] <= data;
			end
			// Lane parity of a frame is the XOR of all its line bytes
			if (fp) begin
				prev_bip <= bip_acc;
				bip_acc <= data;
			end else begin
				bip_acc <= bip_acc ^ data;
			end
		end
	end
endmodule
`default_nettype wire

//--- sonet_tx_overhead_scrambler_test.sv
`timescale 1ns/100ps
`default_nettype none
module sonet_tx_overhead_scrambler_test;
	import sonet_tx_pkg::*;
	typedef struct { logic [17:0] addr; logic [7:0] wdata; logic [7:0] rdata; } row_s;
	logic        clk_sys = 1'b0;
	logic        arst_n = 1'b0;
	logic [7:0]  tx_data = 8'h3C;
	logic        tx_fp = 1'b0;
	logic        reg_wr = 1'b0;
	logic [17:0] reg_addr = 18'h00000;
	logic [7:0]  reg_wdata = 8'h00;
	wire  [7:0]  reg_rdata;
	wire  [7:0]  work_data;
	wire  [7:0]  prot_data;
	wire         byte_en;
	wire         out_valid;
	wire         out_fp;
	int          n_errors = 0;
	int          num_checks = 0;
	int          in_pos = 8000;
	int          lat = 0;
	int          n_en = 0;
	bit          lat_ok = 1'b0;
	logic        fp_d = 1'b0;
	logic [7:0]  exp_rep [0:3] = '{8'h00, 8'h0F, 8'hF0, 8'hFF};
	row_s        rows [0:7] = '{'{18'h3000F, 8'h5A, 8'h5A}, '{18'h3000E, 8'h55, 8'h55},
		'{18'h30010, 8'hAA, 8'hAA}, '{18'h30011, 8'h77, 8'h00}, '{18'h3000D, 8'h80, 8'h00},
		'{18'h3000C, 8'h41, 8'h41}, '{18'h3000F, 8'h0F, 8'h0F}, '{18'h3000D, 8'h01, 8'h01}};

	always #2 clk_sys = ~clk_sys;

	sonet_tx_overhead_scrambler sonet_tx_overhead_scrambler_i (.CLK_SYS(clk_sys), .ARST_N(arst_n),
		.TX_DATA(tx_data), .TX_FP(tx_fp), .REG_WR(reg_wr), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
		.REG_RDATA(reg_rdata), .BYTE_EN(byte_en), .TX_WORK_DATA(work_data), .TX_PROT_DATA(prot_data),
		.TX_OUT_VALID(out_valid), .TX_OUT_FP(out_fp));
	sonet_rx_monitor sonet_rx_monitor_i (.clk(clk_sys), .arst_n(arst_n), .data(work_data),
		.valid(out_valid), .fp(out_fp));

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic reg_write(input logic [17:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		#1;
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge clk_sys);
		#1;
		reg_wr = 1'b0;
	endtask

	task automatic reg_check(input logic [17:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		#1;
		reg_addr = a;
		#1;
		check($sformatf("register %h", a), exp, reg_rdata);
	endtask

	// Waits for a byte index on the input side or on the line side
	task automatic wait_cnt(input bit use_in, input int p);
		int k;
		k = 0;
		while ((use_in ? in_pos : sonet_rx_monitor_i.pos) != p && k < 40000) begin
			@(posedge clk_sys);
			k++;
		end
		#1;
		if (k >= 40000) begin
			check("position wait", 8'h01, 8'h00);
		end
	endtask

	function automatic logic [7:0] hdr_exp(input int c, input bit corrupt);
		if (corrupt && c == 11) return 8'h55;
		if (corrupt && c == 12) return 8'hAA;
		return (c < 12) ? A1_BYTE : A2_BYTE;
	endfunction

	task automatic check_hdr(input bit corrupt);
		for (int c = 0; c < 24; c++) begin
			check($sformatf("framing %0d", c), hdr_exp(c, corrupt), sonet_rx_monitor_i.cap[c]);
		end
	endtask

	// Feeder: frame pulse with byte 0 of each 9720-byte frame; tx_data stays constant, so no overhead bytes arrive
	always @(posedge clk_sys) begin
		#1;
		if (byte_en) begin
			tx_fp = (in_pos == 0);
			in_pos = (in_pos == 9719) ? 0 : in_pos + 1;
		end
	end

	always @(posedge clk_sys) begin
		if (byte_en && tx_fp) begin
			lat = 0;
			lat_ok = 1'b1;
		end else if (byte_en) begin
			lat++;
		end
		if (out_fp && !fp_d && lat_ok) begin
			check("frame latency", 8'h01, {7'h00, lat >= 5 && lat <= 7});
		end
		fp_d = out_fp;
		if (out_valid) begin
			check("protect copy", work_data, prot_data);
		end
	end

	initial begin
		repeat (2) @(posedge clk_sys);
		check("valid in reset", 8'h00, {7'h00, out_valid});
		#1;
		arst_n = 1'b1;
		for (int i = 0; i < 5; i++) begin
			reg_check(OFS_FRAME_COUNT_AND_SCRAMBLE + 18'(i), 8'h00);
		end
		$display("test reset done");
		foreach (rows[i]) begin
			reg_write(rows[i].addr, rows[i].wdata);
			reg_check(rows[i].addr, rows[i].rdata);
		end
		$display("test registers done");
		repeat (2500) @(posedge clk_sys) if (byte_en) n_en++;
		check("byte rate", 8'h01, {7'h00, n_en inside {777, 778}});
		$display("test byte rate done");
		wait_cnt(1'b1, 20);
		wait_cnt(1'b0, 30);
		check_hdr(1'b1);
		reg_check(OFS_FRAMING_ERR_CTRL_A, 8'h81);
		reg_write(OFS_FRAMING_ERR_CTRL_A, 8'h09);
		$display("test burst done");
		wait_cnt(1'b1, 20);
		wait_cnt(1'b0, 1091);
		check_hdr(1'b0);
		check("clear payload", 8'h3C, sonet_rx_monitor_i.cap[36]);
		check("parity", sonet_rx_monitor_i.prev_bip ^ 8'h0F, sonet_rx_monitor_i.cap[1080]);
		for (int c = 1081; c < 1092; c++) begin
			check($sformatf("parity fill %0d", c), 8'h00, sonet_rx_monitor_i.cap[c]);
		end
		reg_write(OFS_FRAMING_ERR_CTRL_A, 8'h08);
		reg_write(OFS_FRAME_COUNT_AND_SCRAMBLE, 8'h00);
		reg_write(OFS_FRAMING_ERR_CTRL_A, 8'h09);
		$display("test parity done");
		wait_cnt(1'b1, 20);
		wait_cnt(1'b0, 40);
		check_hdr(1'b1);
		reg_check(OFS_FRAMING_ERR_CTRL_A, 8'h09);
		for (int c = 24; c < 36; c++) begin
			check($sformatf("bypass %0d", c), 8'h3C, sonet_rx_monitor_i.cap[c]);
		end
		check("scrambled payload", 8'h3C ^ 8'hFE, sonet_rx_monitor_i.cap[36]);
		$display("test scrambler done");
		reg_write(OFS_FRAME_COUNT_AND_SCRAMBLE, 8'h40);
		reg_write(OFS_FRAMING_ERR_CTRL_A, 8'h10);
		tx_data = 8'h1B;
		wait_cnt(1'b0, 300);
		// Bit pairs of 1B give a distinct byte at each phase, so a nibble swap shows
		repeat (400) @(posedge clk_sys) if (out_valid) check("expanded", exp_rep[sonet_rx_monitor_i.idx % 4], work_data);
		$display("test expansion done");
		stop_test();
	end

	// About 70k cycles of traffic expected; cut off at 90k
	initial begin
		#360000;
		n_errors++;
		stop_test();
	end
endmodule
`default_nettype wire
